/* include/link_status_pkg.sv */
// shared constants, types and register map of the link and route status manager
// assumes one 10 MHz system clock and an Avalon-MM master with waitrequest
//
// How it works
// - deactivate link on link or external management request
// - inactive link activated after both-end alignment
// - processor outage from remote marks link blocked
// - remote outage ended clears blocked condition
// - failed, deactivated, blocked or inhibited means unavailable
// - available again once no condition remains
// - local inhibit set on remote acknowledgement
// - remote inhibit only if destinations stay reachable
// - remote or local uninhibit request clears inhibit
// - uninhibit acknowledgement clears inhibit after own request
// - unavailable link starts changeover where needed
// - failure starts restoration, maybe extra link activation
// - failure or deactivation may start prohibited/restricted
// - link back in service starts changeback, except during outage hold
// - restored link deactivates extra link activated meanwhile
// - restoration or activation may start transfer-allowed
// - too few active links, activate another
// - too many active links, deactivate another
// - optional local outage around blocking, then hold
// - blocking/unblocking/uninhibit drive route set procedures
// - route state from prohibited/allowed/restricted messages
// - unavailable route forces rerouting and propagation
// - level-2 failure, management or changeover order fails link
// - failed link restored after both-end alignment
package link_status_pkg;

   localparam int N_LINK = 4;
   localparam int N_ROUTE = 4;
   localparam int CLK_HZ = 10_000_000;
   localparam int HOLD_MS = 100;
   localparam int HOLD_CYC = (HOLD_MS * (CLK_HZ / 1000));
   localparam int HOLD_W = 20;

   localparam logic [4:0] OFS_CTRL = 5'h00;
   localparam logic [4:0] OFS_CMD = 5'h04;
   localparam logic [4:0] OFS_LINK_STAT = 5'h08;
   localparam logic [4:0] OFS_ROUTE_STAT = 5'h0c;

   localparam int CTRL_LPO_BIT = 0;
   localparam int CTRL_STP_BIT = 1;
   localparam int CTRL_RESTR_BIT = 2;
   localparam int CTRL_NORM_LSB = 4;
   localparam logic [7:0] CTRL_RST = 8'h22;

   localparam int CMD_LINK_LSB = 0;
   localparam int CMD_OP_LSB = 4;

   localparam int ST_W = 8;
   localparam int ST_FI = 0;
   localparam int ST_IK = 1;
   localparam int ST_BL = 2;
   localparam int ST_LI = 3;
   localparam int ST_RI = 4;
   localparam int ST_AV = 5;
   localparam int ST_HOLD = 6;
   localparam int ST_EX = 7;

   localparam logic LINK_RST_INACTIVE = 1'b1;

   typedef enum logic [2:0] {
      OP_NONE = 3'h0,
      OP_DEACT = 3'h1,
      OP_FAIL = 3'h2,
      OP_INHIBIT = 3'h3,
      OP_UNINH_LOCAL = 3'h4,
      OP_UNINH_REQ = 3'h5,
      OP_HOLD_CANCEL = 3'h6
   } cmd_op_t;

   typedef enum logic [1:0] {
      RT_AVAIL = 2'h0,
      RT_RESTR = 2'h1,
      RT_UNAV = 2'h3
   } route_state_t;

   typedef enum logic [1:0] {
      SQ_IDLE = 2'h0,
      SQ_LPO = 2'h1,
      SQ_TM = 2'h3,
      SQ_HOLD = 2'h2
   } seq_state_t;

   typedef struct packed {
      logic [N_LINK-1:0] fail;
      logic [N_LINK-1:0] align_ok;
      logic [N_LINK-1:0] po_start;
      logic [N_LINK-1:0] po_end;
      logic [N_LINK-1:0] co_order;
      logic [N_LINK-1:0] inh_ack;
      logic [N_LINK-1:0] uninh_ack;
      logic [N_LINK-1:0] rem_inh_req;
      logic [N_LINK-1:0] rem_uninh_req;
   } link_ind_t;

   typedef struct packed {
      logic [N_LINK-1:0] changeover;
      logic [N_LINK-1:0] changeback;
      logic [N_LINK-1:0] restore;
      logic [N_LINK-1:0] lpo;
      logic [N_LINK-1:0] inh_req;
      logic [N_LINK-1:0] uninh_req;
      logic [N_LINK-1:0] inh_refuse;
   } link_proc_t;

   typedef struct packed {
      logic tfp;
      logic tfa;
      logic tfr;
      logic [1:0] dest;
   } route_msg_t;

   typedef struct packed {
      logic act_other;
      logic deact_other;
      logic tfp_start;
      logic tfa_start;
      logic tfr_start;
      logic [N_ROUTE-1:0] reroute;
      logic [N_ROUTE-1:0] dest_tfp;
   } mgmt_act_t;

endpackage : link_status_pkg

/* logic/block_hold_seq.sv */
// per-link sequencer for local outage around blocking and the hold afterwards
// assumes start and cancel are single-cycle pulses on the system clock
`timescale 1ns/1ps
module block_hold_seq #(
   parameter int HOLD_CYCLES = link_status_pkg::HOLD_CYC
) (
   input wire logic clk_sys_i,
   input wire logic rstn_i,
   input wire logic start_i,
   input wire logic cancel_i,
   output logic lpo_o,
   output logic co_o,
   output logic hold_o
);

   link_status_pkg::seq_state_t state_reg, state_next;
   logic [link_status_pkg::HOLD_W-1:0] cnt_reg, cnt_next;
   localparam logic [link_status_pkg::HOLD_W-1:0] HOLD_LAST =
      link_status_pkg::HOLD_W'(HOLD_CYCLES - 1);

   wire logic timer_done = (cnt_reg == HOLD_LAST);

   always_comb begin
      state_next = state_reg;
      cnt_next = cnt_reg;
      case (state_reg)
         link_status_pkg::SQ_IDLE: begin
            if (start_i) begin
               state_next = link_status_pkg::SQ_LPO;
            end
         end
         link_status_pkg::SQ_LPO: state_next = link_status_pkg::SQ_TM;
         link_status_pkg::SQ_TM: begin
            state_next = link_status_pkg::SQ_HOLD;
            cnt_next = '0;
         end
         link_status_pkg::SQ_HOLD: begin
            cnt_next = cnt_reg + 1'b1;
            if (timer_done || cancel_i) begin
               state_next = link_status_pkg::SQ_IDLE;
            end
         end
         default: state_next = link_status_pkg::SQ_IDLE;
      endcase
   end

   always_ff @(posedge clk_sys_i or negedge rstn_i) begin
      if (!rstn_i) begin
         state_reg <= link_status_pkg::SQ_IDLE;
         cnt_reg <= '0;
      end else begin
         state_reg <= state_next;
         cnt_reg <= cnt_next;
      end
   end

   assign lpo_o = (state_reg == link_status_pkg::SQ_LPO) || (state_reg == link_status_pkg::SQ_TM);
   assign co_o = (state_reg == link_status_pkg::SQ_TM);
   assign hold_o = (state_reg != link_status_pkg::SQ_IDLE);

   AST_SEQ_ORDER: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
      (state_reg == link_status_pkg::SQ_IDLE) && start_i |=> lpo_o && !co_o ##1 lpo_o && co_o
      ##1 !lpo_o && hold_o)
      else $error("outage sequence out of order");

endmodule : block_hold_seq

/* logic/link_route_status.sv */
// link and route status manager with Avalon-MM register slave
// assumes level-2 terminal and route message decoder sit on the same clock
`timescale 1ns/1ps
module link_route_status #(
   parameter int HOLD_CYCLES = link_status_pkg::HOLD_CYC
) (
   input wire logic clk_sys_i,
   input wire logic rstn_i,
   input wire logic [4:0] avs_address_i,
   input wire logic avs_read_i,
   input wire logic avs_write_i,
   input wire logic [31:0] avs_writedata_i,
   input wire logic [3:0] avs_byteenable_i,
   output logic [31:0] avs_readdata_o,
   output logic avs_waitrequest_o,
   input wire link_status_pkg::link_ind_t l2_ind_i,
   input wire link_status_pkg::route_msg_t route_msg_i,
   output link_status_pkg::link_proc_t link_proc_o,
   output link_status_pkg::mgmt_act_t mgmt_o
);

   localparam int NL = link_status_pkg::N_LINK;
   localparam int NR = link_status_pkg::N_ROUTE;

   function automatic logic [2:0] count_set(input logic [NL-1:0] v);
      count_set = 3'h0;
      for (int k = 0; k < NL; k++) begin
         count_set = count_set + {2'h0, v[k]};
      end
   endfunction : count_set

   function automatic link_status_pkg::route_state_t set_level(input logic [2:0] cnt,
         input logic [2:0] norm, input logic restr_en);
      if (cnt == 3'h0) begin
         set_level = link_status_pkg::RT_UNAV;
      end else if (restr_en && (cnt < norm)) begin
         set_level = link_status_pkg::RT_RESTR;
      end else begin
         set_level = link_status_pkg::RT_AVAIL;
      end
   endfunction : set_level

   // bus slave: one wait cycle, answer at the second edge
   logic ack_reg;
   logic [31:0] rdata_reg;
   logic [7:0] ctrl_reg;
   wire logic bus_req = avs_read_i || avs_write_i;
   wire logic wr_fire = avs_write_i && ack_reg;
   wire logic wr_ctrl = wr_fire && (avs_address_i == link_status_pkg::OFS_CTRL)
      && avs_byteenable_i[0];
   wire logic cmd_fire = wr_fire && (avs_address_i == link_status_pkg::OFS_CMD)
      && avs_byteenable_i[0];
   wire logic [1:0] cmd_link = avs_writedata_i[link_status_pkg::CMD_LINK_LSB +: 2];
   wire logic [2:0] cmd_op = avs_writedata_i[link_status_pkg::CMD_OP_LSB +: 3];
   wire logic [7:0] ctrl_next = wr_ctrl ? avs_writedata_i[7:0] : ctrl_reg;
   wire logic lpo_en = ctrl_reg[link_status_pkg::CTRL_LPO_BIT];
   wire logic stp_en = ctrl_reg[link_status_pkg::CTRL_STP_BIT];
   wire logic restr_en = ctrl_reg[link_status_pkg::CTRL_RESTR_BIT];
   wire logic [2:0] norm = ctrl_reg[link_status_pkg::CTRL_NORM_LSB +: 3];

   assign avs_waitrequest_o = bus_req && !ack_reg;
   assign avs_readdata_o = rdata_reg;

   logic [NL-1:0] fi_reg, fi_next;
   logic [NL-1:0] ik_reg, ik_next;
   logic [NL-1:0] bl_reg, bl_next;
   logic [NL-1:0] li_reg, li_next;
   logic [NL-1:0] ri_reg, ri_next;
   logic [NL-1:0] ip_reg, ip_next;
   logic [NL-1:0] up_reg, up_next;
   logic [NL-1:0] ex_reg, ex_next;
   logic [NL-1:0] avail_reg, avail_next;
   logic [NL-1:0] fail_ev, deact_ev, align_ev, block_ev, unblock_ev;
   logic [NL-1:0] linh_ev, rinh_ok, rinh_refuse, uninh_ev, inh_send, uninh_send;
   logic [NL-1:0] down, up_t, seq_start, seq_lpo, seq_co, hold, cmd_hit, cancel;
   logic [NL*link_status_pkg::ST_W-1:0] link_stat;

   generate
      for (genvar i = 0; i < NL; i++) begin : g_link
         localparam logic [NL-1:0] SELF = NL'(1) << i;
         wire logic others_avail = |(avail_reg & ~SELF);
         assign cmd_hit[i] = cmd_fire && (cmd_link == 2'(i));
         assign fail_ev[i] = !fi_reg[i] && (l2_ind_i.fail[i]
            || (cmd_hit[i] && (cmd_op == link_status_pkg::OP_FAIL))
            || (l2_ind_i.co_order[i] && avail_reg[i]));
         assign deact_ev[i] = cmd_hit[i] && (cmd_op == link_status_pkg::OP_DEACT)
            && !(fi_reg[i] && ik_reg[i]);
         assign align_ev[i] = l2_ind_i.align_ok[i] && fi_reg[i];
         assign block_ev[i] = l2_ind_i.po_start[i] && !bl_reg[i];
         assign unblock_ev[i] = l2_ind_i.po_end[i] && bl_reg[i];
         assign linh_ev[i] = l2_ind_i.inh_ack[i] && ip_reg[i];
         assign rinh_ok[i] = l2_ind_i.rem_inh_req[i] && others_avail;
         assign rinh_refuse[i] = l2_ind_i.rem_inh_req[i] && !others_avail;
         assign uninh_ev[i] = (li_reg[i] || ri_reg[i]) && (l2_ind_i.rem_uninh_req[i]
            || (cmd_hit[i] && (cmd_op == link_status_pkg::OP_UNINH_LOCAL))
            || (l2_ind_i.uninh_ack[i] && up_reg[i]));
         assign inh_send[i] = cmd_hit[i] && (cmd_op == link_status_pkg::OP_INHIBIT)
            && !li_reg[i] && !ip_reg[i];
         assign uninh_send[i] = cmd_hit[i] && (cmd_op == link_status_pkg::OP_UNINH_REQ)
            && li_reg[i] && !up_reg[i];
         assign cancel[i] = cmd_hit[i] && (cmd_op == link_status_pkg::OP_HOLD_CANCEL);
         // set wins over clear on every flag
         assign fi_next[i] = fail_ev[i] || deact_ev[i] || (fi_reg[i] && !align_ev[i]);
         assign ik_next[i] = deact_ev[i] || (ik_reg[i] && !fail_ev[i]);
         assign bl_next[i] = block_ev[i] || (bl_reg[i] && !unblock_ev[i]);
         assign li_next[i] = linh_ev[i] || (li_reg[i] && !uninh_ev[i]);
         assign ri_next[i] = rinh_ok[i] || (ri_reg[i] && !uninh_ev[i]);
         assign ip_next[i] = inh_send[i] || (ip_reg[i] && !l2_ind_i.inh_ack[i]);
         assign up_next[i] = uninh_send[i] || (up_reg[i] && !l2_ind_i.uninh_ack[i]);
         assign avail_next[i] = !(fi_next[i] || bl_next[i] || li_next[i] || ri_next[i]);
         assign down[i] = avail_reg[i] && !avail_next[i];
         assign up_t[i] = !avail_reg[i] && avail_next[i];
         assign seq_start[i] = block_ev[i] && lpo_en && down[i];
         block_hold_seq #(
            .HOLD_CYCLES(HOLD_CYCLES)
         ) u_seq (
            .clk_sys_i(clk_sys_i),
            .rstn_i(rstn_i),
            .start_i(seq_start[i]),
            .cancel_i(cancel[i]),
            .lpo_o(seq_lpo[i]),
            .co_o(seq_co[i]),
            .hold_o(hold[i])
         );
         assign link_stat[i*link_status_pkg::ST_W +: link_status_pkg::ST_W] = {ex_reg[i],
            hold[i], avail_reg[i], ri_reg[i], li_reg[i], bl_reg[i], ik_reg[i], fi_reg[i]};
      end
   endgenerate

   // link set counts drive activation and route set procedures
   wire logic [2:0] cnt_now = count_set(avail_reg);
   wire logic [2:0] cnt_nx = count_set(avail_next);
   wire link_status_pkg::route_state_t lvl_now = set_level(cnt_now, norm, restr_en);
   wire link_status_pkg::route_state_t lvl_nx = set_level(cnt_nx, norm, restr_en);
   wire logic short_set = (cnt_nx < norm);
   wire logic long_set = (cnt_nx > norm);
   wire logic [NL-1:0] restored = align_ev & ~ik_reg;
   assign ex_next = (fail_ev & {NL{short_set}}) | (ex_reg & ~align_ev);

   link_status_pkg::link_proc_t proc_reg, proc_next;
   link_status_pkg::mgmt_act_t mgmt_reg, mgmt_next;
   link_status_pkg::route_state_t rt_reg [NR];
   link_status_pkg::route_state_t rt_next [NR];
   logic [NR*2-1:0] route_stat;

   always_comb begin
      // changeover on link loss held off during outage hold; the sequencer issues its own changeover
      proc_next.changeover = (down & ~hold & ~seq_start) | seq_co;
      proc_next.changeback = up_t & ~hold;
      proc_next.restore = fail_ev;
      proc_next.lpo = seq_lpo;
      proc_next.inh_req = inh_send;
      proc_next.uninh_req = uninh_send;
      proc_next.inh_refuse = rinh_refuse;
   end

   generate
      for (genvar r = 0; r < NR; r++) begin : g_route
         wire logic hit = (route_msg_i.dest == 2'(r));
         assign rt_next[r] = (hit && route_msg_i.tfp) ? link_status_pkg::RT_UNAV :
            (hit && route_msg_i.tfr) ? link_status_pkg::RT_RESTR :
            (hit && route_msg_i.tfa) ? link_status_pkg::RT_AVAIL : rt_reg[r];
         assign mgmt_next.reroute[r] = (rt_next[r] == link_status_pkg::RT_UNAV)
            && (rt_reg[r] != link_status_pkg::RT_UNAV);
         assign mgmt_next.dest_tfp[r] = mgmt_next.reroute[r] && stp_en;
         assign route_stat[r*2 +: 2] = rt_reg[r];
      end
   endgenerate

   assign mgmt_next.act_other = |(fail_ev | deact_ev | linh_ev | rinh_ok) && short_set;
   assign mgmt_next.deact_other = (|(up_t & ~restored) && long_set) || |(restored & ex_reg);
   assign mgmt_next.tfp_start = stp_en && (lvl_nx == link_status_pkg::RT_UNAV)
      && (lvl_now != link_status_pkg::RT_UNAV);
   assign mgmt_next.tfr_start = stp_en && (lvl_nx == link_status_pkg::RT_RESTR)
      && (lvl_now != link_status_pkg::RT_RESTR);
   assign mgmt_next.tfa_start = stp_en && (lvl_nx == link_status_pkg::RT_AVAIL)
      && (lvl_now != link_status_pkg::RT_AVAIL);

   wire logic [31:0] rd_mux =
      (avs_address_i == link_status_pkg::OFS_CTRL) ? {24'h0, ctrl_reg} :
      (avs_address_i == link_status_pkg::OFS_LINK_STAT) ? link_stat :
      (avs_address_i == link_status_pkg::OFS_ROUTE_STAT) ? {24'h0, route_stat} : 32'h0;

   always_ff @(posedge clk_sys_i or negedge rstn_i) begin
      if (!rstn_i) begin
         ack_reg <= 1'b0;
         rdata_reg <= 32'h0;
         ctrl_reg <= link_status_pkg::CTRL_RST;
      end else begin
         ack_reg <= bus_req && !ack_reg;
         rdata_reg <= (avs_read_i && !ack_reg) ? rd_mux : rdata_reg;
         ctrl_reg <= ctrl_next;
      end
   end

   // links start inactive until aligned
   always_ff @(posedge clk_sys_i or negedge rstn_i) begin
      if (!rstn_i) begin
         fi_reg <= {NL{link_status_pkg::LINK_RST_INACTIVE}};
         ik_reg <= {NL{link_status_pkg::LINK_RST_INACTIVE}};
         bl_reg <= '0;
         li_reg <= '0;
         ri_reg <= '0;
         ip_reg <= '0;
         up_reg <= '0;
         ex_reg <= '0;
         avail_reg <= '0;
      end else begin
         fi_reg <= fi_next;
         ik_reg <= ik_next;
         bl_reg <= bl_next;
         li_reg <= li_next;
         ri_reg <= ri_next;
         ip_reg <= ip_next;
         up_reg <= up_next;
         ex_reg <= ex_next;
         avail_reg <= avail_next;
      end
   end

   always_ff @(posedge clk_sys_i or negedge rstn_i) begin
      if (!rstn_i) begin
         proc_reg <= '0;
         mgmt_reg <= '0;
         for (int r = 0; r < NR; r++) begin
            rt_reg[r] <= link_status_pkg::RT_AVAIL;
         end
      end else begin
         proc_reg <= proc_next;
         mgmt_reg <= mgmt_next;
         for (int r = 0; r < NR; r++) begin
            rt_reg[r] <= rt_next[r];
         end
      end
   end

   assign link_proc_o = proc_reg;
   assign mgmt_o = mgmt_reg;

   default clocking cb @(posedge clk_sys_i);
   endclocking
   default disable iff (!rstn_i);

   AST_FAIL_MARK: assert property (
      l2_ind_i.fail[0] && !fi_reg[0] |=> fi_reg[0] && !ik_reg[0] && !avail_reg[0])
      else $error("level-2 failure did not fail the link");
   AST_DEACT_MARK: assert property (
      deact_ev[1] |=> fi_reg[1] && ik_reg[1] && !avail_reg[1])
      else $error("deactivation request not applied");
   AST_ALIGN_ONLY: assert property (
      $fell(fi_reg[0]) |-> $past(l2_ind_i.align_ok[0]))
      else $error("link left failed or inactive without alignment");
   AST_BLOCK_MARK: assert property (
      l2_ind_i.po_start[2] |=> bl_reg[2] && !avail_reg[2])
      else $error("remote outage did not block the link");
   AST_UNBLOCK_CAUSE: assert property (
      $fell(bl_reg[2]) |-> $past(l2_ind_i.po_end[2]))
      else $error("blocked cleared without outage end");
   AST_AVAIL_RISE: assert property (
      $rose(avail_reg[0]) |-> !fi_reg[0] && !bl_reg[0] && !li_reg[0] && !ri_reg[0])
      else $error("link available while a condition remains");
   AST_LOCAL_INH: assert property (
      $rose(li_reg[3]) |-> $past(ip_reg[3]) && $past(l2_ind_i.inh_ack[3]))
      else $error("local inhibit without acknowledgement");
   AST_REMOTE_INH: assert property (
      $rose(ri_reg[3]) |-> $past(|avail_reg[NL-2:0]))
      else $error("remote inhibit would isolate destinations");
   AST_CHANGEOVER: assert property (
      down[0] && !hold[0] && !seq_start[0] |=> link_proc_o.changeover[0])
      else $error("changeover missing on link loss");
   AST_CHANGEBACK: assert property (
      up_t[0] && !hold[0] |=> link_proc_o.changeback[0] && avail_reg[0])
      else $error("changeback missing on link return");
   AST_ROUTE_TFP: assert property (
      route_msg_i.tfp && (route_msg_i.dest == 2'h1) |=> rt_reg[1] == link_status_pkg::RT_UNAV)
      else $error("prohibited message did not mark route unavailable");
   AST_BUS_WAIT: assert property (
      bus_req && avs_waitrequest_o |=> !avs_waitrequest_o)
      else $error("waitrequest held longer than one cycle");

   AST_CO_ORDER: assert property (
      l2_ind_i.co_order[0] && avail_reg[0] |=> fi_reg[0] && !avail_reg[0])
      else $error("changeover order did not fail the link");
   AST_RESTORE: assert property (
      fail_ev[0] |=> link_proc_o.restore[0] && fi_reg[0])
      else $error("restoration not started on failure");
   AST_EXTRA_DEACT: assert property (
      align_ev[0] && !ik_reg[0] && ex_reg[0] |=> mgmt_o.deact_other && !ex_reg[0])
      else $error("extra link not released after restoration");
   AST_AVAIL_CAUSE: assert property (
      $rose(avail_reg[0]) |-> $past(l2_ind_i.align_ok[0] || l2_ind_i.po_end[0]
      || l2_ind_i.rem_uninh_req[0] || l2_ind_i.uninh_ack[0] || cmd_hit[0]))
      else $error("link became available with no restoring event");
   AST_REMOTE_REFUSE: assert property (
      l2_ind_i.rem_inh_req[0] && !(|avail_reg[NL-1:1]) |=> link_proc_o.inh_refuse[0])
      else $error("remote inhibit not refused");
   AST_UNINH_CLEAR: assert property (
      l2_ind_i.rem_uninh_req[3] && !l2_ind_i.rem_inh_req[3] && !l2_ind_i.inh_ack[3]
      |=> !li_reg[3] && !ri_reg[3])
      else $error("uninhibit request left the link inhibited");
   AST_UNINH_ACK: assert property (
      $fell(li_reg[3]) |-> $past(l2_ind_i.rem_uninh_req[3] || l2_ind_i.uninh_ack[3]
      || cmd_hit[3]))
      else $error("local inhibit cleared without request or acknowledgement");
   AST_LPO_FIRST: assert property (
      seq_start[2] && !hold[2] |=> !link_proc_o.lpo[2] ##1 link_proc_o.lpo[2]
      ##1 link_proc_o.lpo[2] && link_proc_o.changeover[2])
      else $error("local outage not applied before changeover");
   AST_HOLD_MASK: assert property (
      hold[2] |=> !link_proc_o.changeback[2])
      else $error("changeback during post-blocking hold");
   AST_ROUTE_TFR: assert property (
      route_msg_i.tfr && !route_msg_i.tfp && (route_msg_i.dest == 2'h1)
      |=> rt_reg[1] == link_status_pkg::RT_RESTR)
      else $error("restricted message did not mark route restricted");
   AST_ROUTE_TFA: assert property (
      route_msg_i.tfa && !route_msg_i.tfp && !route_msg_i.tfr && (route_msg_i.dest == 2'h1)
      |=> rt_reg[1] == link_status_pkg::RT_AVAIL)
      else $error("allowed message did not mark route available");
   AST_REROUTE: assert property (
      route_msg_i.tfp && (route_msg_i.dest == 2'h1) && (rt_reg[1] != link_status_pkg::RT_UNAV)
      |=> mgmt_o.reroute[1] && (mgmt_o.dest_tfp[1] == $past(stp_en)))
      else $error("forced rerouting missing on route loss");

   COV_FAIL_RESTORE: cover property (fail_ev[0] ##[1:20] align_ev[0]);
   COV_BLOCK_SEQ: cover property (seq_start[2] ##3 hold[2]);
   COV_ROUTE_REROUTE: cover property (mgmt_o.reroute[1]);
   COV_TFA: cover property (mgmt_o.tfa_start);

endmodule : link_route_status

/* verif/l2_far_end.sv */
// far-end model: level-2 terminal and remote signalling point
// assumes bench supplies alignment, outage and remote requests
`timescale 1ns/1ps
module l2_far_end (
   input wire logic clk_sys_i,
   input wire logic rstn_i,
   input wire link_status_pkg::link_proc_t proc_i,
   input wire link_status_pkg::link_ind_t ind_i,
   output link_status_pkg::link_ind_t ind_o
);
   logic [link_status_pkg::N_LINK-1:0] inh_ack_reg;
   logic [link_status_pkg::N_LINK-1:0] uninh_ack_reg;
   always_ff @(posedge clk_sys_i or negedge rstn_i) begin
      if (!rstn_i) begin
         inh_ack_reg <= '0;
         uninh_ack_reg <= '0;
      end else begin
         inh_ack_reg <= proc_i.inh_req;
         uninh_ack_reg <= proc_i.uninh_req;
      end
   end
   always_comb begin
      ind_o = ind_i;
      ind_o.inh_ack = ind_i.inh_ack | inh_ack_reg;
      ind_o.uninh_ack = ind_i.uninh_ack | uninh_ack_reg;
   end
endmodule : l2_far_end

/* verif/link_route_status_bench.sv */
// self-checking bench for the link and route status manager
// assumes the far-end model acknowledges inhibit requests
`timescale 1ns/1ps
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin mismatches++; \
   $display("wrong value at %0t: got %h exp %h", $time, (g), (e)); end end
module link_route_status_bench;
   logic clk_sys_i = 1'b0;
   logic rstn_i = 1'b0;
   logic [4:0] adr = 5'h00;
   logic rd_en = 1'b0;
   logic wr_en = 1'b0;
   logic [31:0] wdata = 32'h0;
   logic [31:0] rdata;
   logic wait_req;
   link_status_pkg::link_ind_t ind_tb = '0;
   link_status_pkg::link_ind_t ind;
   link_status_pkg::route_msg_t rmsg = '0;
   link_status_pkg::link_proc_t proc;
   link_status_pkg::mgmt_act_t mgmt;
   link_status_pkg::link_proc_t seen_p = '0;
   link_status_pkg::mgmt_act_t seen_m = '0;
   int mismatches = 0;
   int cmp_count = 0;
   logic [31:0] q;

   link_route_status #(.HOLD_CYCLES(20)) uut (
      .clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .avs_address_i(adr), .avs_read_i(rd_en),
      .avs_write_i(wr_en), .avs_writedata_i(wdata), .avs_byteenable_i(4'hf),
      .avs_readdata_o(rdata), .avs_waitrequest_o(wait_req), .l2_ind_i(ind),
      .route_msg_i(rmsg), .link_proc_o(proc), .mgmt_o(mgmt));
   l2_far_end far (.clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .proc_i(proc), .ind_i(ind_tb),
      .ind_o(ind));

   initial begin
      forever #50 clk_sys_i = ~clk_sys_i;
   end
   // pulses last one cycle (lpo two), so keep them sticky
   always @(posedge clk_sys_i) begin
      seen_p = seen_p | proc;
      seen_m = seen_m | mgmt;
   end

   task automatic final_report;
      $display("compares %0d mismatches %0d", cmp_count, mismatches);
      if (mismatches == 0 && cmp_count > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask : final_report

   task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk_sys_i);
      adr <= a;
      wdata <= d;
      wr_en <= w;
      rd_en <= ~w;
      do begin
         @(posedge clk_sys_i);
         n++;
      end while (wait_req && n < 50);
      if (n >= 50) begin
         mismatches++;
         final_report();
      end
      q = rdata;
      wr_en <= 1'b0;
      rd_en <= 1'b0;
   endtask : bus

   task automatic rchk(input logic [4:0] a, input logic [31:0] m, input logic [31:0] e);
      bus(1'b0, a, 32'h0);
      `CHK(q & m, e)
   endtask : rchk

   task automatic rlink(input logic [31:0] m, input logic [31:0] e);
      rchk(link_status_pkg::OFS_LINK_STAT, m, e);
   endtask : rlink

   task automatic clr;
      @(negedge clk_sys_i);
      seen_p = '0;
      seen_m = '0;
   endtask : clr

   task automatic cmd(input logic [2:0] op, input logic [1:0] ln);
      clr();
      bus(1'b1, link_status_pkg::OFS_CMD, {25'h0, op, 2'h0, ln});
      repeat (4) @(posedge clk_sys_i);
   endtask : cmd

   function automatic link_status_pkg::link_ind_t ev(input int f, input logic [3:0] b);
      ev = '0;
      ev[35-4*f -: 4] = b;
   endfunction : ev

   task automatic pulse(input link_status_pkg::link_ind_t v);
      clr();
      @(posedge clk_sys_i);
      ind_tb <= v;
      @(posedge clk_sys_i);
      ind_tb <= '0;
      repeat (3) @(posedge clk_sys_i);
   endtask : pulse

   task automatic rt(input logic [2:0] m, input logic [1:0] e);
      clr();
      @(posedge clk_sys_i);
      rmsg <= link_status_pkg::route_msg_t'({m, 2'h1});
      @(posedge clk_sys_i);
      rmsg <= '0;
      rchk(link_status_pkg::OFS_ROUTE_STAT, 32'hc, {28'h0, e, 2'h0});
   endtask : rt

   initial begin
      #1_000_000;
      mismatches++;
      final_report();
   end

   initial begin
      repeat (3) @(posedge clk_sys_i);
      rstn_i <= 1'b1;
      rchk(link_status_pkg::OFS_CTRL, 32'hff, 32'h22);
      rlink(32'hffffffff, 32'h03030303);
      rchk(link_status_pkg::OFS_ROUTE_STAT, 32'hff, 32'h0);
      rchk(5'h10, 32'hffffffff, 32'h0);
      $display("test reset done");
      pulse(ev(1, 4'hf));
      rlink(32'h21212121, 32'h20202020);
      `CHK(seen_p.changeback, 4'hf)
      `CHK({seen_m.deact_other, seen_m.tfa_start}, 2'h3)
      $display("test activation done");
      pulse(ev(0, 4'h1));
      rlink(32'h21, 32'h01);
      `CHK(seen_p.changeover[0] & seen_p.restore[0], 1'b1)
      pulse(ev(1, 4'h1));
      rlink(32'h21, 32'h20);
      `CHK(seen_p.changeback[0], 1'b1)
      cmd(3'h1, 2'h1);
      rlink(32'h2100, 32'h0100);
      `CHK(seen_p.changeover[1], 1'b1)
      $display("test failure done");
      bus(1'b1, link_status_pkg::OFS_CTRL, 32'h23);
      pulse(ev(2, 4'h4));
      rlink(32'h640000, 32'h440000);
      `CHK(seen_p.lpo[2], 1'b1)
      cmd(3'h6, 2'h2);
      rlink(32'h400000, 32'h0);
      pulse(ev(3, 4'h4));
      rlink(32'h240000, 32'h200000);
      $display("test blocking done");
      cmd(3'h3, 2'h3);
      rlink(32'h28000000, 32'h08000000);
      `CHK(seen_p.inh_req[3], 1'b1)
      cmd(3'h5, 2'h3);
      rlink(32'h28000000, 32'h20000000);
      `CHK(seen_p.uninh_req[3], 1'b1)
      pulse(ev(7, 4'h8));
      rlink(32'h10000000, 32'h10000000);
      pulse(ev(8, 4'h8));
      rlink(32'h10000000, 32'h0);
      pulse(ev(4, 4'h1));
      rlink(32'h21, 32'h01);
      $display("test inhibit done");
      rt(3'h4, 2'h3);
      `CHK({seen_m.reroute[1], seen_m.dest_tfp[1]}, 2'h3)
      rt(3'h1, 2'h1);
      rt(3'h2, 2'h0);
      $display("test routes done");
      final_report();
   end
endmodule : link_route_status_bench
